// ---- bench/core_seq_model.sv ----
/*
  model of the core instruction sequencer and of the event sources.
  assumes the block answers on ack and that the bench calls run() from
  just after a rising edge of pclk.
*/
`timescale 1ns/1ps
module core_seq_model (
  input wire logic pclk, // machine cycle clock
  input wire nest_irq_pkg::ack_s ack, // acknowledge answer
  output nest_irq_pkg::instr_s instr, // sequencer state
  output logic basic_timer_event, // timer pulse
  output logic ext_both_edge_event, // edge input pulse
  output logic [4:0] other_src_event // vectors 1..5 pulses
);
  import nest_irq_pkg::*;

  // idle sequencer and quiet sources from time zero
  initial begin
    instr = '0;
    {other_src_event, ext_both_edge_event, basic_timer_event} = 7'h00;
  end

  // one instruction of n cycles; the event mask m fires in cycle ev
  task automatic run(input int n, input logic [11:0] a, input logic [2:0] k, input int ev,
    input logic [6:0] m, output logic took, output int bc);
    for (int i = 0; i < n; i++) begin
      @(posedge pclk);
      instr <= '{done: i == n - 1, last_cycle: i == n - 1, addr: a, ei: k[2] && i == n - 1,
        di: k[1] && i == n - 1, return_from_irq_instr: k[0] && i == n - 1};
      {other_src_event, ext_both_edge_event, basic_timer_event} <= (i == ev) ? m : 7'h00;
    end
    @(posedge pclk);
    instr <= '0;
    {other_src_event, ext_both_edge_event, basic_timer_event} <= 7'h00;
    #1;
    took = ack.busy;
    bc = 0;
    // the core stalls while acknowledge runs; bounded so a stuck busy shows as a bad count
    while (ack.busy === 1'b1 && bc < 8) begin
      @(posedge pclk);
      #1;
      bc++;
    end
  endtask
endmodule

// ---- bench/tb_nested_interrupt_acknowledge.sv ----
/*
  self-checking bench for the nested interrupt acknowledge block.
  assumes the register map and timings of the defines header.
*/
`timescale 1ns/1ps
`include "nest_irq_defines.svh"
module tb_nested_interrupt_acknowledge;
  import nest_irq_pkg::*;
  localparam logic [11:0] CTL = 12'hFB0; // control page address
  localparam logic [11:0] ORD = 12'h020; // ordinary data address
  localparam logic [2:0] K_EI = 3'h4; // enable-all
  localparam logic [2:0] K_DI = 3'h2; // disable-all
  localparam logic [2:0] K_RT = 3'h1; // return
  logic pclk = 1'b0; // machine clock
  logic presetn, psel, penable, pwrite; // apb controls
  logic [7:0] paddr; // apb address
  logic [31:0] pwdata, prdata; // apb data
  logic pready, pslverr; // apb answer
  instr_s instr; // sequencer
  logic bt_ev, eb_ev; // shared sources
  logic [4:0] oth_ev; // other sources
  ack_s ack; // acknowledge
  logic master_enable_flag; // master enable
  logic [1:0] nest_status; // nesting status
  int num_errors = 0;
  int samples_checked = 0;

  // 100 mhz clock
  always #5 pclk = ~pclk;

  nest_irq_ack nest_irq_ack_inst (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .instr(instr), .basic_timer_event(bt_ev), .ext_both_edge_event(eb_ev),
    .other_src_event(oth_ev), .ack(ack), .master_enable_flag(master_enable_flag),
    .nest_status(nest_status));

  core_seq_model core_seq_model_inst (.pclk(pclk), .ack(ack), .instr(instr), .basic_timer_event(bt_ev),
    .ext_both_edge_event(eb_ev), .other_src_event(oth_ev));

  task automatic end_of_test;
    $display("checked %0d errors %0d", samples_checked, num_errors);
    if (num_errors == 0 && samples_checked > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask

  task automatic chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp) begin
      num_errors++;
      $display("ERROR %s expected %h seen %h", nm, exp, got);
    end
  endtask

  // one apb transfer; request held until pready is seen at a rising edge
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
    output logic [31:0] r, output logic e);
    int n;
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    // pready is read at the edge itself, before that edge updates it
    @(posedge pclk);
    while (pready !== 1'b1 && n < 20) begin
      @(posedge pclk);
      n++;
    end
    if (pready !== 1'b1) begin
      num_errors++;
      end_of_test();
    end
    r = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] r;
    logic e;
    apb(1'b1, a, d, r, e);
  endtask

  task automatic rd(input logic [7:0] a, input logic [31:0] exp, input string nm);
    logic [31:0] r;
    logic e;
    apb(1'b0, a, 32'h0, r, e);
    chk(nm, r, exp);
  endtask

  // one instruction, then whether acknowledge followed and for how long
  task automatic go(input int n, input logic [11:0] a, input logic [2:0] k, input int ev,
    input logic [6:0] m, input logic exp, input string nm);
    logic took;
    int bc;
    core_seq_model_inst.run(n, a, k, ev, m, took, bc);
    chk(nm, {31'h0, took}, {31'h0, exp});
    if (exp === 1'b1) chk("busy_len", 32'(bc), {30'h0, `ACK_CYCLES});
  endtask

  task automatic st(input logic [1:0] exp);
    #1; // a write taken at this very edge must settle first
    chk("nest", {30'h0, nest_status}, {30'h0, exp});
  endtask

  // main sequence
  initial begin
    logic [31:0] r;
    logic e;
    presetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0;
    repeat (10) @(posedge pclk);
    presetn <= 1'b1;
    rd(`OFF_CTRL, 32'h0, "ctrl");
    st(2'h0);
    chk("me", {31'h0, master_enable_flag}, 32'h0);
    apb(1'b0, 8'h40, 32'h0, r, e);
    chk("slverr", {31'h0, e}, 32'h1);
    wr(`OFF_VEC_BANK, 32'h3);
    wr(`OFF_ENABLE, 32'h1);
    wr(`OFF_REQ_SET, 32'h1);
    go(2, ORD, 3'h0, -1, 7'h00, 1'b0, "no_master");
    go(1, CTL, K_EI, -1, 7'h00, 1'b0, "ei");
    chk("me", {31'h0, master_enable_flag}, 32'h1);
    go(2, ORD, 3'h0, -1, 7'h00, 1'b1, "sw_flag");
    chk("bank", {30'h0, ack.mem_bank_enable, ack.reg_bank_enable}, 32'h3);
    st(2'h1);
    rd(`OFF_REQUEST, 32'h0, "req_clr");
    go(1, ORD, K_RT, -1, 7'h00, 1'b0, "return_from_irq_instr");
    st(2'h0);
    wr(`OFF_REQ_SET, 32'h2);
    go(2, ORD, 3'h0, -1, 7'h00, 1'b0, "edge_off");
    go(3, ORD, 3'h0, 0, 7'h01, 1'b1, "early");
    go(1, ORD, K_RT, -1, 7'h00, 1'b0, "return_from_irq_instr");
    go(2, ORD, 3'h0, 0, 7'h01, 1'b1, "early_l1");
    go(1, ORD, K_RT, -1, 7'h00, 1'b0, "return_from_irq_instr");
    go(3, ORD, 3'h0, 2, 7'h01, 1'b0, "late");
    go(2, ORD, 3'h0, -1, 7'h00, 1'b1, "late_next");
    go(1, ORD, K_RT, -1, 7'h00, 1'b0, "return_from_irq_instr");
    go(2, CTL, 3'h0, 0, 7'h01, 1'b0, "ctl1");
    go(1, CTL, 3'h0, -1, 7'h00, 1'b0, "ctl2");
    go(2, ORD, 3'h0, -1, 7'h00, 1'b1, "ctl_next");
    go(1, ORD, K_RT, -1, 7'h00, 1'b0, "return_from_irq_instr");
    go(1, CTL, K_DI, 0, 7'h01, 1'b0, "di");
    go(2, ORD, 3'h0, -1, 7'h00, 1'b0, "held");
    go(1, CTL, K_EI, -1, 7'h00, 1'b0, "ei");
    go(2, ORD, 3'h0, -1, 7'h00, 1'b1, "released");
    go(1, ORD, K_RT, -1, 7'h00, 1'b0, "return_from_irq_instr");
    wr(`OFF_ENABLE, 32'h3);
    wr(`OFF_REQ_SET, 32'h3);
    go(2, ORD, 3'h0, -1, 7'h00, 1'b1, "shared_or");
    rd(`OFF_REQUEST, 32'h3, "both_kept");
    wr(`OFF_REQUEST, 32'h1);
    rd(`OFF_REQUEST, 32'h2, "one_left");
    go(2, ORD, 3'h0, -1, 7'h00, 1'b0, "low_wait");
    go(1, ORD, K_RT, -1, 7'h00, 1'b0, "return_from_irq_instr");
    go(2, ORD, 3'h0, -1, 7'h00, 1'b1, "remainder");
    wr(`OFF_REQUEST, 32'h2);
    go(1, ORD, K_RT, -1, 7'h00, 1'b0, "return_from_irq_instr");
    wr(`OFF_ENABLE, 32'h5);
    wr(`OFF_CTRL, 32'h1);
    wr(`OFF_REQ_SET, 32'h4);
    go(2, ORD, 3'h0, -1, 7'h00, 1'b1, "low_st0");
    chk("vec", {29'h0, ack.vector}, 32'h1);
    wr(`OFF_REQ_SET, 32'h4);
    go(2, ORD, 3'h0, -1, 7'h00, 1'b0, "low_st1");
    wr(`OFF_REQ_SET, 32'h1);
    go(2, ORD, 3'h0, -1, 7'h00, 1'b1, "high_nest");
    st(2'h2);
    wr(`OFF_REQ_SET, 32'h1);
    go(2, ORD, 3'h0, -1, 7'h00, 1'b0, "depth2");
    // the status rewrite below is done with interrupts held off
    go(1, CTL, K_DI, -1, 7'h00, 1'b0, "di");
    wr(`OFF_CTRL, 32'h1);
    st(2'h0);
    go(1, CTL, K_EI, -1, 7'h00, 1'b0, "ei");
    go(2, ORD, 3'h0, -1, 7'h00, 1'b1, "reopen");
    chk("vec", {29'h0, ack.vector}, 32'h0);
    rd(`OFF_STATUS, 32'h60, "status");
    end_of_test();
  end
endmodule

// ---- rtl/nest_irq_ack.sv ----
/*
  interrupt acceptance, two-level nesting and acknowledge timing,
  with an apb register file.
  assumes the core sequencer drives instr on pclk, ignores its own
  instruction flow while ack.busy is high, and that sources deliver
  one-cycle event pulses already synchronous to pclk.
*/
// The placing of the registers and register access over APB were chosen for this implementation.
`timescale 1ns/1ps
`include "nest_irq_defines.svh"

// How it works
// [RULE_01] high priority source accepted in status 0/1
// [RULE_02] priority nesting alone stops at two levels
// [RULE_03] status zeroed by software reopens all sources
// [RULE_04] software changes status only after disable-all; the block takes a status write in any cycle without an ack end or a return
// [RULE_05] one enabled sharing source drives shared request
// [RULE_06] single enabled sharing source: flag cleared on ack
// [RULE_07] both sharing sources enabled: request is OR
// [RULE_08] both enabled: ack leaves both flags set
// [RULE_09] remaining shared flag keeps request asserted
// [RULE_10] high priority shared remainder nests at once
// [RULE_11] low priority shared remainder waits for return
// [RULE_12] control instruction: one more, then ack
// [RULE_13] chained control instructions all run first
// [RULE_14] disable-all holds request until enable-all
// [RULE_15] control instructions address data memory fbxh
// [RULE_16] set in last cycle: one more instruction
// [RULE_17] set earlier: ack right after this instruction
// [RULE_18] software set flag behaves like hardware
// [RULE_19] ack loads bank enables from vector table
// [RULE_20] source enable alone insufficient; master enable needed
// [RULE_21] reset disables all, status zero
// [RULE_22] ack advances status, clears accepted flag
// [RULE_23] return restores saved status
// [RULE_24] simultaneous requests resolved by fixed order
// [RULE_25] flags hold until acknowledged or cleared; an ack of vector 0 with one shared source on clears all enabled flags
module nest_irq_ack #(
  parameter int NSRC = 7,       // sources, 0 and 1 share vector 0
  parameter int NVEC = 6,       // vectored requests
  parameter int STACK_DEPTH = 4 // saved status entries
) (
  input wire logic pclk, // machine cycle clock
  input wire logic presetn, // async reset, active low
  input wire logic psel, // apb select
  input wire logic penable, // apb access phase
  input wire logic pwrite, // apb direction
  input wire logic [7:0] paddr, // apb byte address
  input wire logic [31:0] pwdata, // apb write data
  output logic [31:0] prdata, // apb read data
  output logic pready, // apb ready
  output logic pslverr, // apb error on unmapped address
  input wire nest_irq_pkg::instr_s instr, // core sequencer state
  input wire logic basic_timer_event, // timer event pulse
  input wire logic ext_both_edge_event, // edge input event pulse
  input wire logic [4:0] other_src_event, // vectors 1..5 events
  output nest_irq_pkg::ack_s ack, // acknowledge answer
  output logic master_enable_flag, // interrupts enabled
  output logic [1:0] nest_status // current processing status
);
  import nest_irq_pkg::*;

  // registers
  logic [3:0] priority_select_reg_q; // chosen high priority vector
  logic [NSRC-1:0] source_enable_flag_q; // per source enables
  logic [NSRC-1:0] source_request_flag_q; // pending requests
  logic [NSRC-1:0] source_request_flag_d;
  logic [11:0] vec_bank_q; // mbe/rbe per vector
  logic master_enable_q; // master enable
  logic [1:0] nest_q; // processing status
  logic [1:0] nest_stack_q [STACK_DEPTH]; // saved status words
  logic [$clog2(STACK_DEPTH)-1:0] sp_q; // stack pointer
  ack_state_e state_q; // acknowledge sequencer state
  logic [1:0] ack_cnt_q; // cycles spent in acknowledge
  ack_s ack_q; // answer towards core
  logic early_q; // request may be taken at this instruction end
  logic [31:0] prdata_q;
  logic pready_q;
  logic pslverr_q;

  // combinational terms
  logic [NSRC-1:0] events; // all event pulses in source order
  logic [NVEC-1:0] vectored_request;
  logic [NVEC-1:0] accept;
  logic eligible; // some vector may be taken now
  logic [2:0] sel_vec; // chosen vector
  logic go; // acknowledge starts at this edge
  logic ack_end; // last acknowledge cycle
  logic bus_wr;
  logic bus_setup;

  // decode of the interrupt control instruction class
  function automatic logic is_ctrl(input logic [11:0] a); // [RULE_15]
    return a[11:4] == `IRQ_CTRL_PAGE;
  endfunction

  // status after acknowledge: 0 goes to 1, 1 goes to 2
  function automatic logic [1:0] next_status(input logic [1:0] s);
    return (s == `NEST_ST0) ? `NEST_ST1 : `NEST_ST2;
  endfunction

  // vector chosen as high priority; codes 0 and 7..15 select none
  function automatic logic is_hi(input logic [3:0] p, input logic [2:0] v);
    return (p != 4'h0) && (p <= 4'h6) && (p[2:0] == v + 3'h1);
  endfunction

  assign events = {other_src_event, ext_both_edge_event, basic_timer_event};
  assign bus_setup = psel && !penable;
  assign bus_wr = psel && penable && pwrite && pready_q;
  assign ack_end = (state_q == ACK_RUN) && (ack_cnt_q == `ACK_CYCLES - 2'h1);

  // shared vector: only enabled sources count, ored when both are on
  always_comb begin
    vectored_request[0] = (source_request_flag_q[0] && source_enable_flag_q[0]) || // [RULE_05] [RULE_07]
      (source_request_flag_q[1] && source_enable_flag_q[1]); // [RULE_09]
    for (int i = 1; i < NVEC; i++) begin
      vectored_request[i] = source_request_flag_q[i+1] && source_enable_flag_q[i+1];
    end
  end

  // high priority is taken in status 0 and 1, low priority only in 0
  always_comb begin
    for (int i = 0; i < NVEC; i++) begin
      accept[i] = master_enable_q && vectored_request[i] && // [RULE_20]
        ((nest_q == `NEST_ST0) || // [RULE_03]
        ((nest_q == `NEST_ST1) && is_hi(priority_select_reg_q, 3'(i)))); // [RULE_01] [RULE_02] [RULE_10] [RULE_11]
    end
  end

  // fixed order: the lowest vector wins, the rest stay pending, but if vector 0 wins with one shared source enabled its ack clears them
  always_comb begin
    sel_vec = 3'h0;
    for (int i = NVEC - 1; i >= 0; i--) begin
      if (accept[i]) begin
        sel_vec = 3'(i); // [RULE_24]
      end
    end
  end

  assign eligible = |accept;
  // take at the end of an ordinary instruction; a flag seen in that final cycle
  // was set before it, one set in the final cycle shows only in the next one
  assign go = (state_q == ACK_IDLE) && instr.done && !is_ctrl(instr.addr) && // [RULE_12] [RULE_13]
    eligible; // [RULE_14] [RULE_16] [RULE_17]

  // armed: an accepted request waits for the end of an ordinary instruction;
  // kept for software only, the take decision itself needs no history, so a
  // one-cycle instruction right after a late flag still ends in acknowledge
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      early_q <= 1'b0;
    end else begin
      early_q <= (state_q == ACK_IDLE) && eligible && !go;
    end
  end

  // acknowledge sequencer: three machine cycles of stack work
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_q <= ACK_IDLE;
      ack_cnt_q <= 2'h0;
      ack_q <= '0;
    end else begin
      case (state_q)
        ACK_IDLE: begin
          if (go) begin
            state_q <= ACK_RUN;
            ack_cnt_q <= 2'h0;
            ack_q.busy <= 1'b1;
            ack_q.vector <= sel_vec;
            ack_q.mem_bank_enable <= vec_bank_q[{sel_vec, 1'b0}]; // [RULE_19]
            ack_q.reg_bank_enable <= vec_bank_q[{sel_vec, 1'b1}];
          end
        end
        ACK_RUN: begin
          ack_cnt_q <= ack_cnt_q + 2'h1;
          if (ack_end) begin
            state_q <= ACK_IDLE; // [RULE_12]
            ack_q.busy <= 1'b0;
          end
        end
        default: begin
          state_q <= ACK_IDLE;
        end
      endcase
    end
  end

  // master enable follows the enable-all and disable-all instructions
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      master_enable_q <= 1'b0; // [RULE_21]
    end else if (instr.di) begin
      master_enable_q <= 1'b0; // [RULE_14]
    end else if (instr.ei) begin
      master_enable_q <= 1'b1; // [RULE_20]
    end
  end

  // status: hardware steps win over a software write in the same cycle;
  // software is expected to write it only with interrupts disabled
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      nest_q <= `NEST_RST; // [RULE_21]
      sp_q <= '0;
    end else if (ack_end) begin
      nest_stack_q[sp_q] <= nest_q;
      sp_q <= sp_q + 1'b1; // wraps silently beyond STACK_DEPTH levels
      nest_q <= next_status(nest_q); // [RULE_22]
    end else if (instr.return_from_irq_instr) begin
      nest_q <= nest_stack_q[sp_q - 1'b1]; // [RULE_23]
      sp_q <= sp_q - 1'b1;
    end else if (bus_wr && paddr == `OFF_CTRL) begin
      nest_q <= pwdata[`CTRL_NEST_LSB +: 2]; // [RULE_03] [RULE_04]
    end
  end

  // request flags: set by events or software, cleared by ack or software;
  // a set in the clearing cycle wins so nothing is lost
  always_comb begin
    source_request_flag_d = source_request_flag_q;
    if (ack_end) begin
      if (ack_q.vector == 3'h0) begin
        if (source_enable_flag_q[0] != source_enable_flag_q[1]) begin
          source_request_flag_d = source_request_flag_d & ~source_enable_flag_q; // [RULE_06]
        end
      end else begin
        source_request_flag_d[ack_q.vector + 3'h1] = 1'b0; // [RULE_22]
      end
    end
    if (bus_wr && paddr == `OFF_REQUEST) begin
      source_request_flag_d = source_request_flag_d & ~pwdata[NSRC-1:0];
    end
    source_request_flag_d = source_request_flag_d | events; // [RULE_25]
    if (bus_wr && paddr == `OFF_REQ_SET) begin
      source_request_flag_d = source_request_flag_d | pwdata[NSRC-1:0]; // [RULE_18]
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      source_request_flag_q <= '0;
    end else begin
      source_request_flag_q <= source_request_flag_d; // [RULE_08]
    end
  end

  // software configuration registers
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      priority_select_reg_q <= `PRIO_RST;
      source_enable_flag_q <= `EN_RST;
      vec_bank_q <= `VB_RST;
    end else if (bus_wr) begin
      case (paddr)
        `OFF_CTRL: priority_select_reg_q <= pwdata[`CTRL_PRIO_LSB +: 4];
        `OFF_ENABLE: source_enable_flag_q <= pwdata[NSRC-1:0];
        `OFF_VEC_BANK: vec_bank_q <= pwdata[11:0];
        default: ;
      endcase
    end
  end

  // apb slave: one wait-free access phase, data prepared in setup
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready_q <= 1'b0;
      pslverr_q <= 1'b0;
      prdata_q <= 32'h0;
    end else begin
      pready_q <= bus_setup;
      if (bus_setup) begin
        pslverr_q <= 1'b0;
        prdata_q <= 32'h0;
        case (paddr)
          `OFF_CTRL: prdata_q <= {23'h0, master_enable_q, 2'h0, nest_q, priority_select_reg_q};
          `OFF_ENABLE: prdata_q <= {25'h0, source_enable_flag_q};
          `OFF_REQUEST: prdata_q <= {25'h0, source_request_flag_q};
          `OFF_REQ_SET: prdata_q <= 32'h0;
          `OFF_VEC_BANK: prdata_q <= {20'h0, vec_bank_q};
          `OFF_STATUS: prdata_q <= {25'h0, 2'(sp_q), ack_q.vector, early_q, ack_q.busy};
          default: pslverr_q <= 1'b1; // unmapped address
        endcase
      end
    end
  end

  assign prdata = prdata_q;
  assign pready = pready_q;
  assign pslverr = pslverr_q;
  assign ack = ack_q;
  assign master_enable_flag = master_enable_q;
  assign nest_status = nest_q;

  // checks
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  sequence ack_three_s;
    ack_q.busy [*3] ##1 !ack_q.busy;
  endsequence

  ack_length_a: assert property ($rose(ack_q.busy) |-> ack_three_s) // [RULE_12]
    else $error("acknowledge not three cycles");
  ack_gate_a: assert property ($rose(ack_q.busy) |-> $past(master_enable_q) && // [RULE_20]
    $past(instr.done) && !is_ctrl($past(instr.addr)))
    else $error("acknowledge without enable or at control instruction");
  nest_depth_a: assert property ($rose(ack_q.busy) |-> $past(nest_q) <= `NEST_ST1) // [RULE_02]
    else $error("acknowledge beyond two levels");
  low_prio_a: assert property ($rose(ack_q.busy) && !is_hi(priority_select_reg_q, ack_q.vector) // [RULE_01]
    |-> $past(nest_q) == `NEST_ST0)
    else $error("low priority taken while nested");
  status_step_a: assert property (ack_end |=> nest_q == next_status($past(nest_q))) // [RULE_22]
    else $error("status not advanced on acknowledge");
  status_return_a: assert property (instr.return_from_irq_instr && !ack_end && state_q == ACK_IDLE // [RULE_23]
    |=> nest_q == $past(nest_stack_q[sp_q - 1'b1]))
    else $error("status not restored on return");
  shared_keep_a: assert property (ack_end && ack_q.vector == 3'h0 && &source_enable_flag_q[1:0] && // [RULE_08]
    !(bus_wr && paddr == `OFF_REQUEST)
    |=> ($past(source_request_flag_q[1:0]) & ~source_request_flag_q[1:0]) == 2'h0)
    else $error("shared flag dropped with both sources enabled");
  shared_clear_a: assert property (ack_end && ack_q.vector == 3'h0 && // [RULE_06]
    source_enable_flag_q[1:0] == 2'h1 && !events[0] |=> !source_request_flag_q[0])
    else $error("single shared flag not cleared");
  bank_load_a: assert property ($rose(ack_q.busy) |-> // [RULE_19]
    ack_q.mem_bank_enable == vec_bank_q[{ack_q.vector, 1'b0}] && ack_q.reg_bank_enable == vec_bank_q[{ack_q.vector, 1'b1}])
    else $error("bank enables not loaded from table");
  flag_hold_a: assert property (events[2] |=> source_request_flag_q[2]) // [RULE_25]
    else $error("request event lost");
  // an ordinary instruction end with an enabled status-0 request must start acknowledge
  take_at_end_a: assert property (state_q == ACK_IDLE && instr.done && !is_ctrl(instr.addr) && // [RULE_17]
    master_enable_q && nest_q == `NEST_ST0 && |(source_request_flag_q & source_enable_flag_q)
    |=> $rose(ack_q.busy))
    else $error("pending request not taken at instruction end");
  // a control instruction end never starts acknowledge, whatever is pending
  ctrl_hold_a: assert property (instr.done && is_ctrl(instr.addr) |=> !$rose(ack_q.busy)) // [RULE_13]
    else $error("acknowledge started at control instruction");
  // a dedicated vector drops its own flag when its acknowledge ends
  flag_clear_a: assert property (ack_end && ack_q.vector != 3'h0 && !events[ack_q.vector + 3'h1] && // [RULE_22]
    !(bus_wr && paddr == `OFF_REQ_SET) |=> !source_request_flag_q[ack_q.vector + 3'h1])
    else $error("accepted request flag not cleared");

endmodule

// ---- rtl/nest_irq_defines.svh ----
/*
  offsets, field positions, reset values and timing counts of the
  nested interrupt acknowledge block.
  assumes it is included by bare name into the design files.
*/
`ifndef NEST_IRQ_DEFINES_SVH
`define NEST_IRQ_DEFINES_SVH

// apb register offsets (byte addresses)
`define OFF_CTRL 8'h00
`define OFF_ENABLE 8'h04
`define OFF_REQUEST 8'h08
`define OFF_REQ_SET 8'h0C
`define OFF_VEC_BANK 8'h10
`define OFF_STATUS 8'h14

// control register fields
`define CTRL_PRIO_LSB 0
`define CTRL_NEST_LSB 4
`define CTRL_ME_BIT 8

// reset values
`define PRIO_RST 4'h0
`define NEST_RST 2'h0
`define EN_RST 7'h00
`define VB_RST 12'h000

// nesting status codes
`define NEST_ST0 2'h0
`define NEST_ST1 2'h1
`define NEST_ST2 2'h2

// acknowledge processing length in machine cycles
`define ACK_CYCLES 2'h3

// interrupt control instructions touch data memory fb0h..fbfh
`define IRQ_CTRL_PAGE 8'hFB

`endif

// ---- rtl/nest_irq_pkg.sv ----
/*
  types shared by the nested interrupt acknowledge block.
  assumes nothing outside itself.
*/
package nest_irq_pkg;

  // one machine cycle of the core's instruction sequencer
  typedef struct packed {
    logic done;        // last machine cycle of an instruction
    logic last_cycle;  // current machine cycle is the final one
    logic [11:0] addr; // data memory address touched
    logic ei;          // enable-all instruction executes
    logic di;          // disable-all instruction executes
    logic return_from_irq_instr;        // return-from-interrupt executes
  } instr_s;

  // acknowledge answer towards the core
  typedef struct packed {
    logic busy;        // acknowledge processing in progress
    logic [2:0] vector;// accepted vector, 0 is the shared one
    logic mem_bank_enable;         // memory bank enable from vector table
    logic reg_bank_enable;         // register bank enable from vector table
  } ack_s;

  typedef enum logic {
    ACK_IDLE = 1'b0,
    ACK_RUN = 1'b1
  } ack_state_e;

endpackage
